// ---- verilog/ifl_defines.svh ----
// Purpose: shared constants of the bus flag block: offsets, bit positions, reset values, timing
// Assumes: 50 MHz sys_clk, byte addresses on the register bus
// Notes:   included by the two design files and by the test bench
`ifndef IFL_DEFINES_SVH
`define IFL_DEFINES_SVH

`define IFL_ADDR_W      4
`define IFL_ADDR_CTRL   4'h0
`define IFL_ADDR_FLAG   4'h4

`define IFL_CTRL_EN     7
`define IFL_CTRL_STT    1
`define IFL_FLAG_FAIL   7
`define IFL_FLAG_BUSY   6
`define IFL_FLAG_PERMIT 1
`define IFL_FLAG_RSV    0

`define IFL_RST_BYTE    8'h00
`define IFL_RST_WORD    32'h0000_0000
`define IFL_RST_BIT     1'b0
`define IFL_LINE_IDLE   1'b1
`define IFL_PAD_W       24'h00_0000

`define IFL_CLK_NS      20
`define IFL_HOLD_NS     4000
`define IFL_HOLD_CYC    ((`IFL_HOLD_NS + `IFL_CLK_NS - 1) / `IFL_CLK_NS)
`define IFL_CNT_W       8
`define IFL_CNT_ZERO    8'h00
`define IFL_CNT_ONE     8'h01

`endif

// ---- verilog/ifl_pkg.sv ----
// Purpose: types shared by the bus flag block
// Assumes: ifl_defines.svh holds the numbers
// Notes:   types only
package ifl_pkg;

   // conditions seen on the shared bus, one-cycle pulses
   typedef struct packed {
      logic start;
      logic stop;
   } ifl_cond_type;

   // start generator states
   typedef enum logic [1:0] {
      GEN_IDLE,
      GEN_SDA_LOW,
      GEN_SCL_LOW,
      GEN_SDA_REL
   } ifl_gen_type;

endpackage

// ---- verilog/ifl_line_watch.sv ----
// Purpose: synchronise scl/sda and detect start and stop conditions
// Assumes: scl/sda come from pins, asynchronous to sys_clk
// Notes:   outputs are registered one-cycle pulses
`timescale 1ns/100ps
`include "ifl_defines.svh"

module ifl_line_watch
   import ifl_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic         scl_in,
   input  wire logic         sda_in,
   output ifl_cond_type      cond
);

   logic scl_m_q;
   logic scl_s_q;
   logic scl_p_q;
   logic sda_m_q;
   logic sda_s_q;
   logic sda_p_q;
   ifl_cond_type cond_q;
   ifl_cond_type cond_d;

   // sda edges while scl stays high mark start and stop
   always_comb begin
      cond_d.start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
      cond_d.stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
   end

   // three flops per line; the second and third ones feed the detector
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_m_q <= `IFL_LINE_IDLE;
         scl_s_q <= `IFL_LINE_IDLE;
         scl_p_q <= `IFL_LINE_IDLE;
         sda_m_q <= `IFL_LINE_IDLE;
         sda_s_q <= `IFL_LINE_IDLE;
         sda_p_q <= `IFL_LINE_IDLE;
         cond_q  <= '0;
      end else begin
         scl_m_q <= scl_in;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= sda_in;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
         cond_q  <= cond_d;
      end
   end

   assign cond = cond_q;

endmodule

// ---- verilog/ifl_flag_top.sv ----
// Purpose: start failure, bus busy, initial start permit and reservation flags
// Assumes: Avalon-MM slave with waitrequest, open-drain scl/sda on a shared bus
// Notes:   a minimal start generator exercises the flags; transfers live elsewhere
// Behaviour
// R1 - start failure flag sets when a start cannot be made and start request drops with reservation off.
// R2 - start failure flag clears on a write of 1 to start request or while the unit is disabled.
// R3 - bus busy reads 1 while the bus is in use, 0 when released, and starts at 1 on enable without permit.
// R4 - bus busy sets on a detected start and on enabling the unit with the permit bit at 0.
// R5 - bus busy clears on a detected stop and whenever the unit is disabled.
// R6 - with permit at 0 a start may only be made after a stop has been seen since enable; a start request written together with enable starts at once.
// R7 - with permit at 1 a start may be made at once, the bus taken as released.
// R8 - the permit bit is set only by software and cleared by software or by a detected start.
// R9 - the reservation disable bit turns reservation off at 1 and on at 0, written by software.
// R10 - the failure and busy flags in bits 7 and 6 are read-only.
// R11 - software writes the permit bit only while the unit is disabled.
// R12 - software writes the reservation disable bit only while the unit is disabled.
// R13 - with permit at 1 software checks the bus is quiet before the first start request.
// R14 - start request sits in bit 1 of the control register.
// R15 - unit enable sits in bit 7 of the control register and 0 stops operation.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "ifl_defines.svh"

module ifl_flag_top
   import ifl_pkg::*;
#(
   parameter int HOLD_CYC = `IFL_HOLD_CYC
)(
   input  wire logic                     sys_clk,
   input  wire logic                     nrst,
   input  wire logic [`IFL_ADDR_W-1:0]   avs_address,
   input  wire logic                     avs_read,
   input  wire logic                     avs_write,
   input  wire logic [31:0]              avs_writedata,
   output logic      [31:0]              avs_readdata,
   output logic                          avs_waitrequest,
   input  wire logic                     scl_in,
   output logic                          scl_out,
   output logic                          scl_oe,
   input  wire logic                     sda_in,
   output logic                          sda_out,
   output logic                          sda_oe
);

   localparam logic [`IFL_CNT_W-1:0] HOLD_LAST = `IFL_CNT_W'(HOLD_CYC - 1);

   logic rst_m_q;
   logic rst_n;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic en_q;
   logic fail_q;
   logic fail_d;
   logic busy_q;
   logic busy_d;
   logic permit_q;
   logic permit_d;
   logic rsv_q;
   logic rsv_d;
   ifl_gen_type gen_q;
   ifl_gen_type gen_d;
   logic [`IFL_CNT_W-1:0] cnt_q;
   logic [`IFL_CNT_W-1:0] cnt_d;
   ifl_cond_type cond;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_m_q <= `IFL_RST_BIT;
         rst_n   <= `IFL_RST_BIT;
      end else begin
         rst_m_q <= 1'b1;
         rst_n   <= rst_m_q;
      end
   end

   ifl_line_watch u_watch (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .scl_in  (scl_in),
      .sda_in  (sda_in),
      .cond    (cond)
   );

   // bus decode: one wait cycle, then the answer; unmapped reads give zero
   wire       req      = avs_read | avs_write;
   wire       hit_ctrl = (avs_address == `IFL_ADDR_CTRL);
   wire       hit_flag = (avs_address == `IFL_ADDR_FLAG);
   wire       wr_go    = avs_write & ack_q;
   wire       wr_ctrl  = wr_go & hit_ctrl;
   wire       wr_flag  = wr_go & hit_flag;
   wire [7:0] wbyte    = avs_writedata[7:0];
   wire       stt_w    = wr_ctrl & wbyte[`IFL_CTRL_STT];
   wire       en       = ctrl_q[`IFL_CTRL_EN];
   wire       en_rise  = en & ~en_q;
   // flag byte: bits 5..2 read as zero
   wire [7:0] flag_rd  = {fail_q, busy_q, 4'h0, permit_q, rsv_q};
   wire [31:0] rdata_d = hit_ctrl ? {`IFL_PAD_W, ctrl_q}
                       : hit_flag ? {`IFL_PAD_W, flag_rd} : `IFL_RST_WORD;

   assign avs_waitrequest = req & ~ack_q;
   assign avs_readdata    = rdata_q;

   // start generator decisions taken in idle with a pending request
   wire pend     = (gen_q == GEN_IDLE) & en & ctrl_q[`IFL_CTRL_STT];
   wire gen_go   = pend & ~busy_q;                  // [R6] [R7]
   wire gen_fail = pend & busy_q & rsv_q;           // [R1]
   wire cnt_end  = (cnt_q == HOLD_LAST);
   wire gen_done = (gen_q == GEN_SDA_REL) & cnt_end;

   // control register; hardware drops start request when done, failed or stopped
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = wbyte;                            // [R14] [R15]
      end else if (gen_done | gen_fail) begin
         ctrl_d[`IFL_CTRL_STT] = 1'b0;              // [R1]
      end
      if (!ctrl_d[`IFL_CTRL_EN]) begin
         ctrl_d[`IFL_CTRL_STT] = 1'b0;              // [R15]
      end
   end

   // failure flag: the set wins over a clear in the same cycle
   always_comb begin
      fail_d = fail_q;
      if (gen_fail) begin
         fail_d = 1'b1;                             // [R1]
      end else if (stt_w | ~en) begin
         fail_d = 1'b0;                             // [R2]
      end
   end

   // busy flag follows bus conditions only while enabled
   always_comb begin
      busy_d = busy_q;
      if (!en) begin
         busy_d = 1'b0;                             // [R5]
      end else if (en_rise & ~permit_q) begin
         busy_d = 1'b1;                             // [R3] [R4]
      end else if (cond.start) begin
         busy_d = 1'b1;                             // [R4]
      end else if (cond.stop) begin
         busy_d = 1'b0;                             // [R5]
      end
   end

   // software bits; writes to fail and busy positions fall on the floor
   always_comb begin
      permit_d = permit_q;
      rsv_d    = rsv_q;
      if (wr_flag) begin
         permit_d = wbyte[`IFL_FLAG_PERMIT];        // [R8]
         rsv_d    = wbyte[`IFL_FLAG_RSV];           // [R9] [R10]
      end else if (en & cond.start) begin
         permit_d = 1'b0;                           // [R8]
      end
   end

   // start sequence: sda low, then scl low, then sda released before scl
   always_comb begin
      gen_d = gen_q;
      cnt_d = cnt_end ? `IFL_CNT_ZERO : cnt_q + `IFL_CNT_ONE;
      case (gen_q)
         GEN_IDLE: begin
            cnt_d = `IFL_CNT_ZERO;
            if (gen_go) begin
               gen_d = GEN_SDA_LOW;
            end
         end
         GEN_SDA_LOW: begin
            if (cnt_end) begin
               gen_d = GEN_SCL_LOW;
            end
         end
         GEN_SCL_LOW: begin
            if (cnt_end) begin
               gen_d = GEN_SDA_REL;
            end
         end
         GEN_SDA_REL: begin
            if (cnt_end) begin
               gen_d = GEN_IDLE;
            end
         end
         default: begin
            gen_d = GEN_IDLE;
         end
      endcase
      if (!en) begin
         gen_d = GEN_IDLE;                          // a stop of the unit abandons the sequence
         cnt_d = `IFL_CNT_ZERO;
      end
   end

   // bus handshake and read data
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q   <= `IFL_RST_BIT;
         rdata_q <= `IFL_RST_WORD;
      end else begin
         ack_q <= req & ~ack_q;
         if (req & ~ack_q) begin
            rdata_q <= rdata_d;
         end
      end
   end

   // register state
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q   <= `IFL_RST_BYTE;
         en_q     <= `IFL_RST_BIT;
         fail_q   <= `IFL_RST_BIT;
         busy_q   <= `IFL_RST_BIT;
         permit_q <= `IFL_RST_BIT;
         rsv_q    <= `IFL_RST_BIT;
      end else begin
         ctrl_q   <= ctrl_d;
         en_q     <= en;
         fail_q   <= fail_d;
         busy_q   <= busy_d;
         permit_q <= permit_d;
         rsv_q    <= rsv_d;
      end
   end

   // generator state
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         gen_q <= GEN_IDLE;
         cnt_q <= `IFL_CNT_ZERO;
      end else begin
         gen_q <= gen_d;
         cnt_q <= cnt_d;
      end
   end

   // open-drain drive; the pin level when driven is always low
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_oe <= `IFL_RST_BIT;
         scl_oe <= `IFL_RST_BIT;
      end else begin
         sda_oe <= (gen_d == GEN_SDA_LOW) | (gen_d == GEN_SCL_LOW);
         scl_oe <= (gen_d == GEN_SCL_LOW) | (gen_d == GEN_SDA_REL);
      end
   end

   assign sda_out = `IFL_RST_BIT;
   assign scl_out = `IFL_RST_BIT;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // failure ends with start request low and the flag high, together
   property p_fail_set;
      gen_fail |=> fail_q && (!ctrl_q[`IFL_CTRL_STT] || $past(wr_ctrl));
   endproperty
   a_fail_set: assert property (p_fail_set) else $error("start failure not flagged"); // [R1]

   property p_fail_clr;
      (stt_w || !en) && !gen_fail |=> !fail_q;
   endproperty
   a_fail_clr: assert property (p_fail_clr) else $error("start failure not cleared"); // [R2]

   property p_busy_read;
      avs_read && hit_flag && avs_waitrequest
         |=> avs_readdata[`IFL_FLAG_BUSY] == $past(busy_q);
   endproperty
   a_busy_read: assert property (p_busy_read) else $error("busy read mismatch"); // [R3]

   property p_busy_set;
      en && (cond.start || (en_rise && !permit_q)) |=> busy_q;
   endproperty
   a_busy_set: assert property (p_busy_set) else $error("busy not set"); // [R4]

   property p_busy_clr;
      !en || (cond.stop && !cond.start && !en_rise) |=> !busy_q;
   endproperty
   a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared"); // [R5]

   property p_gen_free;
      $rose(sda_oe) |-> $past(!busy_q) && $past(en);
   endproperty
   a_gen_free: assert property (p_gen_free) else $error("start driven on busy bus"); // [R6]

   property p_permit_clr;
      en && cond.start && !wr_flag |=> !permit_q;
   endproperty
   a_permit_clr: assert property (p_permit_clr) else $error("permit not cleared"); // [R8]

   property p_rsv_wr;
      wr_flag |=> rsv_q == $past(wbyte[`IFL_FLAG_RSV]);
   endproperty
   a_rsv_wr: assert property (p_rsv_wr) else $error("reservation bit not written"); // [R9]

   property p_ro_fail;
      wr_flag && !fail_q && !gen_fail ##1 !gen_fail [*2] |-> !fail_q;
   endproperty
   a_ro_fail: assert property (p_ro_fail) else $error("fail flag written"); // [R10]

   property p_en_wr;
      wr_ctrl |=> en == $past(wbyte[`IFL_CTRL_EN]) ##1 en_q == $past(en);
   endproperty
   a_en_wr: assert property (p_en_wr) else $error("enable bit not at bit 7"); // [R15]

endmodule

// ---- testbench/ifl_bus_party.sv ----
// Purpose: second master on the shared bus, opens and closes frames
// Assumes: open-drain lines with pull-ups, link clock of 160 ns inside frames
// Notes:   scl stands still outside frames; a released line floats high
`timescale 1ns/100ps

module ifl_bus_party (
   output logic scl_low,
   output logic sda_low
);
   // both lines released at time zero
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end

   // start, three clock pulses, then the frame is left open with scl low
   task automatic send_start();
      sda_low = 1'b1;
      #80;
      repeat (3) begin
         scl_low = 1'b1;
         #80;
         scl_low = 1'b0;
         #80;
      end
      scl_low = 1'b1;
      #200;
   endtask

   // stop: scl rises first, sda follows while scl is high
   task automatic send_stop();
      #80;
      scl_low = 1'b0;
      #80;
      sda_low = 1'b0;
      #200;
   endtask
endmodule

// ---- testbench/test_ifl_flag_top.sv ----
// Purpose: self-checking bench for the bus flag block
// Assumes: one wait cycle per register access, short hold count
// Notes:   a second master on the lines makes start and stop conditions
`timescale 1ns/100ps
`include "ifl_defines.svh"

module test_ifl_flag_top;
   typedef struct packed {
      logic [3:0]  a;
      logic [31:0] d;
      logic [31:0] e;
   } ifl_row_type;

   logic                   sys_clk, nrst, avs_read, avs_write, avs_waitrequest;
   logic [`IFL_ADDR_W-1:0] avs_address;
   logic [31:0]            avs_writedata, avs_readdata, rd_q;
   logic                   scl_oe, sda_oe, p_scl, p_sda, scl_w, sda_w, sda_oe_q, scl_oe_q;
   logic                   scl_o, sda_o;
   int                     err_total, total_checks, gen_seen = 0, scl_seen = 0, n;
   ifl_row_type            rows [7];

   // wired-and of all pull-downs over the pull-ups
   assign scl_w = !(scl_oe || p_scl);
   assign sda_w = !(sda_oe || p_sda);

   ifl_flag_top #(.HOLD_CYC(4)) DUT (
      .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .scl_in(scl_w), .scl_out(scl_o), .scl_oe(scl_oe),
      .sda_in(sda_w), .sda_out(sda_o), .sda_oe(sda_oe));

   ifl_bus_party party (.scl_low(p_scl), .sda_low(p_sda));

   // clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // counts starts that this block launches on sda, and scl pulls made while sda is held
   always @(posedge sys_clk) begin
      sda_oe_q <= sda_oe;
      scl_oe_q <= scl_oe;
      if (sda_oe && !sda_oe_q)
         gen_seen <= gen_seen + 1;
      if (scl_oe && !scl_oe_q && sda_oe)
         scl_seen <= scl_seen + 1;
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one avalon access; held until waitrequest is seen low at an edge
   task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge sys_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 20);
      rd_q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (k >= 20) begin
         check("waitrequest", 1, 0);
         end_sim();
      end
   endtask

   task automatic rd(string what, logic [3:0] a, logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(what, rd_q, exp);
   endtask

   // polls until the start request bit drops; the generator is slow on purpose
   task automatic wait_gen();
      n = 0;
      do begin
         bus(1'b0, `IFL_ADDR_CTRL, 32'h0000_0000);
         n++;
      end while (rd_q[1] !== 1'b0 && n < 40);
      if (n >= 40) begin
         check("gen timeout", 1, 0);
         end_sim();
      end
      repeat (8) @(posedge sys_clk);
   endtask

   initial begin
      rows = '{'{4'h0, 32'h0000_007C, 32'h0000_007C}, '{4'h0, 32'h0, 32'h0},
               '{4'h4, 32'h0000_00FF, 32'h0000_0003}, '{4'h4, 32'h0000_0001, 32'h0000_0001},
               '{4'h4, 32'h0, 32'h0}, '{4'h8, 32'h0000_00FF, 32'h0},
               '{4'hC, 32'h0000_005A, 32'h0}};
      nrst = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0000_0000;
      err_total = 0;
      total_checks = 0;
      repeat (10) @(posedge sys_clk);
      check("oe in reset", {28'h0, scl_o, sda_o, scl_oe, sda_oe}, 0);
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd("ctrl reset", `IFL_ADDR_CTRL, 0);
      rd("flag reset", `IFL_ADDR_FLAG, 0);
      // plain register rows, unit stopped throughout
      foreach (rows[i]) begin
         bus(1'b1, rows[i].a, rows[i].d);
         rd("row", rows[i].a, rows[i].e);
      end
      // busy follows enable, start and stop
      bus(1'b1, `IFL_ADDR_CTRL, 32'h0000_0080);
      rd("busy on enable", `IFL_ADDR_FLAG, 32'h0000_0040);
      party.send_start();
      party.send_stop();
      rd("busy after stop", `IFL_ADDR_FLAG, 0);
      party.send_start();
      rd("busy after start", `IFL_ADDR_FLAG, 32'h0000_0040);
      // request waits while busy with reservation on, then goes after a stop
      bus(1'b1, `IFL_ADDR_CTRL, 32'h0000_0082);
      repeat (20) @(posedge sys_clk);
      check("held start", gen_seen, 0);
      rd("held request", `IFL_ADDR_CTRL, 32'h0000_0082);
      party.send_stop();
      wait_gen();
      check("start after stop", gen_seen, 1);
      bus(1'b1, `IFL_ADDR_CTRL, 32'h0000_0000);
      rd("busy off on disable", `IFL_ADDR_FLAG, 0);
      // reservation disabled: failed start sets the flag and drops the request
      bus(1'b1, `IFL_ADDR_FLAG, 32'h0000_0001);
      bus(1'b1, `IFL_ADDR_CTRL, 32'h0000_0080);
      bus(1'b1, `IFL_ADDR_CTRL, 32'h0000_0082);
      rd("fail set", `IFL_ADDR_FLAG, 32'h0000_00C1);
      rd("request dropped", `IFL_ADDR_CTRL, 32'h0000_0080);
      bus(1'b1, `IFL_ADDR_CTRL, 32'h0000_0000);
      rd("fail off on disable", `IFL_ADDR_FLAG, 32'h0000_0001);
      bus(1'b1, `IFL_ADDR_CTRL, 32'h0000_0080);
      bus(1'b1, `IFL_ADDR_CTRL, 32'h0000_0082);
      party.send_start();
      party.send_stop();
      rd("fail kept", `IFL_ADDR_FLAG, 32'h0000_0081);
      bus(1'b1, `IFL_ADDR_CTRL, 32'h0000_0082);
      wait_gen();
      rd("fail off on request", `IFL_ADDR_FLAG, 32'h0000_0041);
      check("second start", gen_seen, 2);
      // permit set: start made at once without a stop, permit then cleared
      bus(1'b1, `IFL_ADDR_CTRL, 32'h0000_0000);
      bus(1'b1, `IFL_ADDR_FLAG, 32'h0000_0002);
      bus(1'b1, `IFL_ADDR_CTRL, 32'h0000_0080);
      rd("no busy with permit", `IFL_ADDR_FLAG, 32'h0000_0002);
      check("lines quiet", {30'h0, scl_w, sda_w}, 3);
      bus(1'b1, `IFL_ADDR_CTRL, 32'h0000_0082);
      wait_gen();
      check("start with permit", gen_seen, 3);
      check("scl after sda", scl_seen, 3);
      rd("permit cleared", `IFL_ADDR_FLAG, 32'h0000_0040);
      // reset in mid-run brings every register back to zero
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd("ctrl after reset", `IFL_ADDR_CTRL, 0);
      rd("flag after reset", `IFL_ADDR_FLAG, 0);
      end_sim();
   end
endmodule
